// ### sbenrd_top.sv
// event notice source and receive drop filter with axi4-lite registers
`timescale 1ns/100ps

module sbenrd_top (
  input  wire logic                          CLK,
  input  wire logic                          RESETN,
  // axi4-lite slave
  input  wire logic [7:0]                    S_AXI_AWADDR,
  input  wire logic                          S_AXI_AWVALID,
  output logic                               S_AXI_AWREADY,
  input  wire logic [31:0]                   S_AXI_WDATA,
  input  wire logic [3:0]                    S_AXI_WSTRB,
  input  wire logic                          S_AXI_WVALID,
  output logic                               S_AXI_WREADY,
  output logic [1:0]                         S_AXI_BRESP,
  output logic                               S_AXI_BVALID,
  input  wire logic                          S_AXI_BREADY,
  input  wire logic [7:0]                    S_AXI_ARADDR,
  input  wire logic                          S_AXI_ARVALID,
  output logic                               S_AXI_ARREADY,
  output logic [31:0]                        S_AXI_RDATA,
  output logic [1:0]                         S_AXI_RRESP,
  output logic                               S_AXI_RVALID,
  input  wire logic                          S_AXI_RREADY,
  // events and event enable command
  input  wire logic [sbenrd_pkg::N_KIND-1:0] EVENT_PULSE,
  input  wire logic                          EVENT_ENABLE_COMMAND,
  input  wire logic [sbenrd_pkg::N_KIND-1:0] EVENT_ENABLE_MASK,
  input  wire logic [7:0]                    EVENT_ENABLE_TAG,
  // notice transmit
  input  wire logic                          TX_ALLOW,
  output logic                               NOTICE_VALID,
  input  wire logic                          NOTICE_READY,
  output sbenrd_pkg::sbenrd_notice_type      NOTICE,
  // receive descriptor at end of frame
  input  wire logic                          RX_DONE,
  input  wire sbenrd_pkg::sbenrd_rxdesc_type RX_DESC,
  input  wire logic                          RX_RESOURCE_READY,
  output logic                               RX_PASS,
  output logic                               RX_RETRY,
  output logic                               RX_DROP,
  output logic [sbenrd_pkg::N_CAUSE-1:0]     RX_DROP_CAUSE,
  // error inputs
  input  wire logic                          RESP_VALID,
  input  wire logic [15:0]                   RESP_CODE,
  input  wire logic                          CONFIG_ERROR,
  input  wire logic                          CMD_LATE_FAIL,
  output logic                               CHAN_INITIAL
);
  import sbenrd_pkg::*;

  // --------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------
  sbenrd_chan_type   chan_state;
  sbenrd_chan_type   next_chan_state;
  logic [HOLD_W-1:0] hold_cnt;
  logic [7:0]        chan_id;
  logic              vendor_long;
  logic [N_KIND-1:0] enable_mask;
  logic [7:0]        host_tag;
  logic [N_KIND-1:0] pend;
  logic [N_KIND-1:0] taken_kind;
  logic              notice_taken;
  logic              sync_err;
  logic [7:0]        last_iid;
  logic              iid_seen;
  logic [CNT_W-1:0]  retry_cnt;
  logic [CNT_W-1:0]  drop_cnt [N_CAUSE];
  logic [N_CAUSE-1:0] causes;
  logic [N_CAUSE-1:0] first_cause;
  logic              async_err;
  logic              soft_init;
  logic              aw_held;
  logic              w_held;
  logic [7:0]        aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              wr_fire;
  logic              rd_fire;

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  function automatic logic [N_CAUSE-1:0] find_causes(
    input sbenrd_rxdesc_type d,
    input logic [7:0]        exp_chan,
    input logic              long_ok,
    input logic              res_ok,
    input logic              in_entry
  );
    logic [10:0] lim;
    logic [N_CAUSE-1:0] c;
    lim = (long_ok && d.is_vendor) ? LEN_VENDOR : LEN_MAX;
    c = '0;
    c[CAUSE_TRANS] = in_entry;
    c[CAUSE_FCS]   = !d.fcs_ok;
    c[CAUSE_LEN]   = (d.length < LEN_MIN) || (d.length > lim);
    c[CAUSE_CSUM]  = d.csum_present && !d.csum_ok;
    c[CAUSE_CHAN]  = d.channel_identifier != exp_chan;
    c[CAUSE_REV]   = d.is_command && (d.revision != HDR_REV);
    c[CAUSE_RES]   = !res_ok;
    return c;
  endfunction

  function automatic logic [31:0] place8(input logic [7:0] v, input int lsb);
    return 32'(v) << lsb;
  endfunction

  function automatic logic [31:0] merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  strb
  );
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  // --------------------------------------------------------------
  // channel state: active, entry into initial, initial
  // --------------------------------------------------------------
  assign async_err    = CONFIG_ERROR || CMD_LATE_FAIL || soft_init;
  assign CHAN_INITIAL = chan_state != CH_ACTIVE;

  always_comb begin
    next_chan_state = chan_state;
    case (chan_state)
      CH_ACTIVE: begin
        if (async_err) begin
          next_chan_state = CH_ENTRY;
        end
      end
      CH_ENTRY: begin
        if (hold_cnt == HOLD_W'(INIT_HOLD_CYC - 1)) begin
          next_chan_state = CH_INITIAL;
        end
      end
      CH_INITIAL: begin
        if (EVENT_ENABLE_COMMAND) begin
          next_chan_state = CH_ACTIVE;
        end
      end
      default: begin
        next_chan_state = CH_INITIAL;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      chan_state <= CH_INITIAL;
    end else begin
      chan_state <= next_chan_state;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      hold_cnt <= '0;
    end else if (chan_state == CH_ENTRY) begin
      hold_cnt <= hold_cnt + 1'b1;
    end else begin
      hold_cnt <= '0;
    end
  end

  // --------------------------------------------------------------
  // event enable command and pending notices
  // --------------------------------------------------------------
  // a retried enable command simply rewrites the same values
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      enable_mask <= '0;
      host_tag    <= '0;
    end else if (chan_state == CH_ENTRY) begin
      enable_mask <= '0;
    end else if (EVENT_ENABLE_COMMAND) begin
      enable_mask <= EVENT_ENABLE_MASK;
      host_tag    <= EVENT_ENABLE_TAG;
    end
  end

  // new event wins over the clear of an older one of the same kind
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      pend <= '0;
    end else if (chan_state != CH_ACTIVE) begin
      pend <= '0;
    end else begin
      pend <= (pend & ~taken_kind) | (EVENT_PULSE & enable_mask);
    end
  end

  sbenrd_notice_gen u_notice (
    .CLK          (CLK),
    .RESETN       (RESETN),
    .pend         (pend),
    .tx_allow     (TX_ALLOW),
    .chan_id      (chan_id),
    .host_tag     (host_tag),
    .taken        (notice_taken),
    .taken_kind   (taken_kind),
    .notice_valid (NOTICE_VALID),
    .notice_ready (NOTICE_READY),
    .notice       (NOTICE)
  );

  // --------------------------------------------------------------
  // receive drop filter
  // --------------------------------------------------------------
  assign causes = find_causes(RX_DESC, chan_id, vendor_long, RX_RESOURCE_READY,
                              chan_state == CH_ENTRY);
  assign first_cause = causes & (~causes + 1'b1);

  // a drop sends no answer and touches no channel state
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      RX_PASS       <= 1'b0;
      RX_DROP       <= 1'b0;
      RX_RETRY      <= 1'b0;
      RX_DROP_CAUSE <= '0;
    end else begin
      RX_PASS       <= RX_DONE && (causes == '0);
      RX_DROP       <= RX_DONE && (causes != '0);
      RX_RETRY      <= RX_DONE && (causes == '0) && iid_seen &&
                       (RX_DESC.instance_identifier == last_iid);
      RX_DROP_CAUSE <= RX_DONE ? first_cause : '0;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      last_iid <= '0;
      iid_seen <= 1'b0;
    end else if (RX_DONE && (causes == '0) && RX_DESC.is_command) begin
      last_iid <= RX_DESC.instance_identifier;
      iid_seen <= 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      retry_cnt <= '0;
    end else if (RX_RETRY) begin
      retry_cnt <= retry_cnt + 1'b1;
    end
  end

  // statistics only; counters saturate rather than wrap
  for (genvar g = 0; g < N_CAUSE; g++) begin : g_drop
    always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
        drop_cnt[g] <= '0;
      end else if (RX_DROP_CAUSE[g] && (drop_cnt[g] != '1)) begin
        drop_cnt[g] <= drop_cnt[g] + 1'b1;
      end
    end
  end

  // sticky; a new failure wins over a same-cycle clear
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      sync_err <= 1'b0;
    end else if (RESP_VALID && (RESP_CODE != 16'h0000)) begin
      sync_err <= 1'b1;
    end else if (wr_fire && (aw_addr == OFS_STATUS) && w_strb[1] &&
                 w_data[ST_SYNCERR_BIT]) begin
      sync_err <= 1'b0;
    end
  end

  // --------------------------------------------------------------
  // axi4-lite write
  // --------------------------------------------------------------
  assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
  assign S_AXI_WREADY  = !w_held && !S_AXI_BVALID;
  assign wr_fire       = aw_held && w_held && !S_AXI_BVALID;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_held <= 1'b1;
      aw_addr <= S_AXI_AWADDR;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_held <= 1'b1;
      w_data <= S_AXI_WDATA;
      w_strb <= S_AXI_WSTRB;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= 2'h0;
    end else if (wr_fire) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= (aw_addr == OFS_CTRL || aw_addr == OFS_STATUS) ? 2'h0 : 2'h2;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      chan_id     <= CHAN_RST;
      vendor_long <= 1'b0;
      soft_init   <= 1'b0;
    end else begin
      soft_init <= 1'b0;
      if (wr_fire && aw_addr == OFS_CTRL) begin
        {vendor_long, chan_id} <= 9'(merge({23'h0, vendor_long, chan_id}, w_data, w_strb));
        soft_init              <= w_strb[1] && w_data[CTRL_INIT_BIT];
      end
    end
  end

  // --------------------------------------------------------------
  // axi4-lite read
  // --------------------------------------------------------------
  assign S_AXI_ARREADY = !S_AXI_RVALID;
  assign rd_fire       = S_AXI_ARVALID && S_AXI_ARREADY;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= '0;
      S_AXI_RRESP  <= 2'h0;
    end else if (rd_fire) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP  <= 2'h0;
      S_AXI_RDATA  <= '0;
      case (S_AXI_ARADDR)
        OFS_CTRL:   S_AXI_RDATA <= place8(chan_id, CTRL_CHAN_LSB) |
                                   (32'(vendor_long) << CTRL_VENDOR_BIT);
        OFS_STATUS: S_AXI_RDATA <= place8(8'(chan_state), ST_STATE_LSB) |
                                   place8(8'(pend), ST_PEND_LSB) |
                                   (32'(sync_err) << ST_SYNCERR_BIT) |
                                   place8(last_iid, ST_IID_LSB);
        OFS_ENABLE: S_AXI_RDATA <= place8(8'(enable_mask), EN_MASK_LSB) |
                                   place8(host_tag, EN_TAG_LSB);
        OFS_RETRY:  S_AXI_RDATA <= 32'(retry_cnt);
        default: begin
          if (S_AXI_ARADDR >= OFS_DROP0 &&
              S_AXI_ARADDR < OFS_DROP0 + 8'(4 * N_CAUSE) && S_AXI_ARADDR[1:0] == 2'h0) begin
            S_AXI_RDATA <= 32'(drop_cnt[3'(S_AXI_ARADDR[7:2] - OFS_DROP0[7:2])]);
          end else begin
            S_AXI_RRESP <= 2'h2;
          end
        end
      endcase
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

endmodule

// ### sbenrd_pkg.sv
// shared constants and carriers for sideband notice and receive drop logic
package sbenrd_pkg;

  // --------------------------------------------------------------
  // clock and timing
  // --------------------------------------------------------------
  localparam int CLK_HZ        = 50_000_000;
  localparam int INIT_HOLD_NS  = 1000;
  localparam int INIT_HOLD_CYC = (INIT_HOLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int HOLD_W        = 8;

  // --------------------------------------------------------------
  // register map (byte addresses)
  // --------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_ENABLE  = 8'h08;
  localparam logic [7:0] OFS_DROP0   = 8'h10;
  localparam logic [7:0] OFS_RETRY   = 8'h30;

  // ctrl fields
  localparam int CTRL_CHAN_LSB   = 0;
  localparam int CTRL_VENDOR_BIT = 8;
  localparam int CTRL_INIT_BIT   = 9;
  localparam logic [7:0] CHAN_RST = 8'h00;

  // status fields
  localparam int ST_STATE_LSB   = 0;
  localparam int ST_PEND_LSB    = 4;
  localparam int ST_SYNCERR_BIT = 8;
  localparam int ST_IID_LSB     = 16;

  // enable fields
  localparam int EN_MASK_LSB = 0;
  localparam int EN_TAG_LSB  = 8;

  // --------------------------------------------------------------
  // packet constants
  // --------------------------------------------------------------
  localparam int         N_KIND      = 3;
  localparam int         N_CAUSE     = 7;
  localparam int         CNT_W       = 16;
  localparam logic [10:0] LEN_MIN    = 11'd64;
  localparam logic [10:0] LEN_MAX    = 11'd1518;
  localparam logic [10:0] LEN_VENDOR = 11'd1536;
  localparam logic [7:0] HDR_REV     = 8'h01;
  localparam logic [7:0] NOTICE_IID  = 8'h00;
  localparam logic [7:0] NOTICE_TYPE = 8'hff;
  localparam logic [7:0] KIND_CODE0  = 8'h00;

  // event kinds, index into enable mask
  localparam int KIND_LINK   = 0;
  localparam int KIND_DRIVER = 1;
  localparam int KIND_RESET  = 2;

  // drop causes, index into counters, lowest index wins
  localparam int CAUSE_TRANS = 0;
  localparam int CAUSE_FCS   = 1;
  localparam int CAUSE_LEN   = 2;
  localparam int CAUSE_CSUM  = 3;
  localparam int CAUSE_CHAN  = 4;
  localparam int CAUSE_REV   = 5;
  localparam int CAUSE_RES   = 6;

  typedef enum logic [2:0] {
    CH_ACTIVE  = 3'h1,
    CH_ENTRY   = 3'h2,
    CH_INITIAL = 3'h4
  } sbenrd_chan_type;

  typedef struct packed {
    logic [10:0] length;
    logic        fcs_ok;
    logic        csum_present;
    logic        csum_ok;
    logic [7:0]  channel_identifier;
    logic        is_command;
    logic        is_vendor;
    logic [7:0]  revision;
    logic [7:0]  instance_identifier;
  } sbenrd_rxdesc_type;

  typedef struct packed {
    logic [7:0] channel_identifier;
    logic [7:0] instance_identifier;
    logic [7:0] host_tag;
    logic [7:0] packet_type;
    logic [7:0] event_code;
  } sbenrd_notice_type;

endpackage

// ### sbenrd_notice_gen.sv
// builds event notice packet headers from pending events
`timescale 1ns/100ps

module sbenrd_notice_gen (
  input  wire logic                          CLK,
  input  wire logic                          RESETN,
  input  wire logic [sbenrd_pkg::N_KIND-1:0] pend,
  input  wire logic                          tx_allow,
  input  wire logic [7:0]                    chan_id,
  input  wire logic [7:0]                    host_tag,
  output logic                               taken,
  output logic [sbenrd_pkg::N_KIND-1:0]      taken_kind,
  output logic                               notice_valid,
  input  wire logic                          notice_ready,
  output sbenrd_pkg::sbenrd_notice_type      notice
);
  import sbenrd_pkg::*;

  logic [N_KIND-1:0] pick;
  logic [7:0]        pick_code;

  // lowest pending kind first; others wait their turn
  always_comb begin
    pick      = '0;
    pick_code = KIND_CODE0;
    for (int k = N_KIND - 1; k >= 0; k--) begin
      if (pend[k]) begin
        pick      = '0;
        pick[k]   = 1'b1;
        pick_code = KIND_CODE0 + 8'(k);
      end
    end
  end

  // one header in flight; held while the link may not send
  assign taken      = !notice_valid && tx_allow && (|pend);
  assign taken_kind = taken ? pick : '0;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      notice_valid <= 1'b0;
    end else if (taken) begin
      notice_valid <= 1'b1;
    end else if (notice_ready) begin
      notice_valid <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      notice <= '0;
    end else if (taken) begin
      notice.channel_identifier  <= chan_id;
      notice.instance_identifier <= NOTICE_IID;
      notice.host_tag            <= host_tag;
      notice.packet_type         <= NOTICE_TYPE;
      notice.event_code          <= pick_code;
    end
  end

endmodule

// ### sbenrd_top_properties.sv
// assertions on notice framing and receive verdict ports
`timescale 1ns/100ps

module sbenrd_top_properties (
  input wire logic                          CLK,
  input wire logic                          RESETN,
  input wire logic                          NOTICE_VALID,
  input wire logic                          NOTICE_READY,
  input wire sbenrd_pkg::sbenrd_notice_type NOTICE,
  input wire logic                          RX_DONE,
  input wire sbenrd_pkg::sbenrd_rxdesc_type RX_DESC,
  input wire logic                          RX_PASS,
  input wire logic                          RX_DROP,
  input wire logic [6:0]                    RX_DROP_CAUSE,
  input wire logic                          CONFIG_ERROR,
  input wire logic                          CHAN_INITIAL
);
  import sbenrd_pkg::*;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);

  property p_iid; NOTICE_VALID |-> NOTICE.instance_identifier == NOTICE_IID; endproperty
  a_iid: assert property (p_iid) else $error("notice id not zero");
  property p_type; NOTICE_VALID |-> NOTICE.packet_type == NOTICE_TYPE; endproperty
  a_type: assert property (p_type) else $error("notice type wrong");
  property p_hold; NOTICE_VALID && !NOTICE_READY |=> NOTICE_VALID && $stable(NOTICE); endproperty
  a_hold: assert property (p_hold) else $error("notice withdrawn");
  property p_verdict; RX_DONE |=> RX_PASS != RX_DROP; endproperty
  a_verdict: assert property (p_verdict) else $error("no single verdict");
  property p_fcs; RX_DONE && !CHAN_INITIAL && !RX_DESC.fcs_ok |=> RX_DROP_CAUSE == 7'h02; endproperty
  a_fcs: assert property (p_fcs) else $error("bad fcs kept");
  property p_len;
    RX_DONE && !CHAN_INITIAL && RX_DESC.fcs_ok && RX_DESC.length < LEN_MIN |=> RX_DROP_CAUSE == 7'h04;
  endproperty
  a_len: assert property (p_len) else $error("runt kept");
  property p_init; !CHAN_INITIAL && CONFIG_ERROR |=> CHAN_INITIAL; endproperty
  a_init: assert property (p_init) else $error("error ignored");
  // past term skips the edge where the channel is just leaving active
  property p_quiet; CHAN_INITIAL && $past(CHAN_INITIAL) && !NOTICE_VALID |=> !NOTICE_VALID; endproperty
  a_quiet: assert property (p_quiet) else $error("notice while not active");
endmodule

// ### sbenrd_host_model.sv
// management host stand-in that takes event notice packets
`timescale 1ns/100ps

module sbenrd_host_model (
  input  wire logic                          CLK,
  input  wire logic                          RESETN,
  input  wire logic                          slow,
  input  wire logic                          notice_valid,
  input  wire sbenrd_pkg::sbenrd_notice_type notice,
  output logic                               notice_ready
);
  import sbenrd_pkg::*;
  sbenrd_notice_type got[$];
  logic [2:0]        wait_cnt;
  // taken notices are never answered; a lost one is simply gone
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      notice_ready <= 1'b0;
      wait_cnt <= 3'h0;
    end else if (notice_valid && notice_ready) begin
      got.push_back(notice);
      notice_ready <= 1'b0;
      wait_cnt <= 3'h0;
    end else if (notice_valid) begin
      wait_cnt <= wait_cnt + 3'h1;
      notice_ready <= !slow || wait_cnt == 3'h6;
    end
  end
endmodule

// ### sbenrd_test.sv
// self-checking bench for sideband notice and receive drop logic
`timescale 1ns/100ps

bind sbenrd_top sbenrd_top_properties chk_i (.*);

module sbenrd_test;
  import sbenrd_pkg::*;
  typedef struct packed {
    sbenrd_rxdesc_type d;
    logic              res;
    logic [6:0]        cause;
    logic              rt;
  } sbenrd_row_type;
  logic CLK = '0, RESETN = '0, S_AXI_AWVALID = '0, S_AXI_WVALID = '0, S_AXI_BREADY = '0;
  logic S_AXI_ARVALID = '0, S_AXI_RREADY = '0, EVENT_ENABLE_COMMAND = '0, TX_ALLOW = '1;
  logic RX_DONE = '0, RX_RESOURCE_READY = '1, RESP_VALID = '0, CONFIG_ERROR = '0;
  logic CMD_LATE_FAIL = '0, slow = '0;
  logic [7:0]  S_AXI_AWADDR = '0, S_AXI_ARADDR = '0, EVENT_ENABLE_TAG = '0;
  logic [31:0] S_AXI_WDATA = '0, S_AXI_RDATA, d;
  logic [3:0]  S_AXI_WSTRB = 4'hf;
  logic [2:0]  EVENT_PULSE = '0, EVENT_ENABLE_MASK = '0;
  logic [15:0] RESP_CODE = '0;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, r;
  logic [6:0]  RX_DROP_CAUSE;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic NOTICE_VALID, NOTICE_READY, RX_PASS, RX_RETRY, RX_DROP, CHAN_INITIAL;
  sbenrd_rxdesc_type RX_DESC = '0;
  sbenrd_notice_type NOTICE;
  sbenrd_row_type    rows [10];
  int comparisons = 0, n_fail = 0;

  always #10 CLK = ~CLK;
  sbenrd_top dut (.*);
  sbenrd_host_model host (.CLK, .RESETN, .slow, .notice_valid(NOTICE_VALID), .notice(NOTICE),
                          .notice_ready(NOTICE_READY));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic sbenrd_row_type mk(logic [10:0] l, logic [3:0] f, logic [7:0] c, v, i,
                                        logic s, logic [6:0] e, logic t);
    mk = '{'{l, f[3], f[2], f[1], c, f[0], 1'b0, v, i}, s, e, t};
  endfunction
  task automatic chk(input logic [39:0] g, e, input string m);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    @(posedge CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= v;
    S_AXI_AWVALID <= '1;
    S_AXI_WVALID <= '1;
    S_AXI_BREADY <= '1;
    do begin
      @(posedge CLK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= '0;
      if (S_AXI_WREADY) S_AXI_WVALID <= '0;
    end while (!S_AXI_BVALID);
    r = S_AXI_BRESP;
    S_AXI_BREADY <= '0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [33:0] e, input string m);
    @(posedge CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= '1;
    S_AXI_RREADY <= '1;
    do begin
      @(posedge CLK);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= '0;
    end while (!S_AXI_RVALID);
    d = S_AXI_RDATA;
    S_AXI_RREADY <= '0;
    chk({S_AXI_RRESP, d}, e, m);
  endtask
  task automatic rx(input sbenrd_row_type w);
    @(posedge CLK);
    RX_DONE <= '1;
    RX_DESC <= w.d;
    RX_RESOURCE_READY <= w.res;
    @(posedge CLK);
    RX_DONE <= '0;
    #1;
    chk({RX_DROP, RX_DROP_CAUSE, RX_PASS, RX_RETRY}, {|w.cause, w.cause, ~|w.cause, w.rt}, "rx");
  endtask
  task automatic pulse(input logic [2:0] ev, en, input logic [7:0] tag);
    @(posedge CLK);
    EVENT_PULSE <= ev;
    EVENT_ENABLE_COMMAND <= |en;
    EVENT_ENABLE_MASK <= en;
    EVENT_ENABLE_TAG <= tag;
    @(posedge CLK);
    EVENT_PULSE <= '0;
    EVENT_ENABLE_COMMAND <= '0;
  endtask
  task automatic wait_got(input int n);
    for (int k = 0; k < 400 && host.got.size() < n; k++) @(posedge CLK);
  endtask
  task automatic tally_and_finish;
    $display("counts: comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    #400us;
    n_fail++;
    tally_and_finish();
  end
  initial begin
    rows = '{mk(11'h040, 4'h9, 8'h05, 8'h01, 8'h01, '1, 7'h00, '0),
             mk(11'h040, 4'h1, 8'h05, 8'h01, 8'h02, '1, 7'h02, '0),
             mk(11'h03f, 4'h9, 8'h05, 8'h01, 8'h02, '1, 7'h04, '0),
             mk(11'h5ef, 4'h9, 8'h05, 8'h01, 8'h02, '1, 7'h04, '0),
             mk(11'h5ee, 4'hd, 8'h05, 8'h01, 8'h02, '1, 7'h08, '0),
             mk(11'h040, 4'h9, 8'h06, 8'h01, 8'h02, '1, 7'h10, '0),
             mk(11'h040, 4'h9, 8'h05, 8'h02, 8'h02, '1, 7'h20, '0),
             mk(11'h5ee, 4'he, 8'h05, 8'h02, 8'h07, '1, 7'h00, '0),
             mk(11'h040, 4'h9, 8'h05, 8'h01, 8'h02, '0, 7'h40, '0),
             mk(11'h040, 4'h9, 8'h05, 8'h01, 8'h01, '1, 7'h00, '1)};
    repeat (16) @(posedge CLK);
    chk(CHAN_INITIAL, 40'h1, "reset state");
    RESETN <= '1;
    rd_chk(OFS_STATUS, 34'h4, "status reset");
    rd_chk(8'h3c, 34'h200000000, "unmapped");
    axw(OFS_ENABLE, 32'hffff);
    chk(r, 40'h2, "read-only write");
    axw(OFS_CTRL, 32'h5);
    pulse(3'h0, 3'h7, 8'ha5);
    // state flop updates in this same time step; look once it has settled
    #1;
    chk(CHAN_INITIAL, 40'h0, "active");
    rd_chk(OFS_ENABLE, 34'ha507, "enable");
    $display("registers done");
    pulse(3'h7, 3'h0, 8'h00);
    wait_got(3);
    for (int k = 0; k < 3; k++)
      chk(host.got[k], {8'h05, NOTICE_IID, 8'ha5, NOTICE_TYPE, KIND_CODE0 + k[7:0]}, "notice");
    $display("notices done");
    foreach (rows[i]) rx(rows[i]);
    rd_chk(OFS_DROP0 + 8'h04, 34'h1, "fcs count");
    rd_chk(OFS_DROP0 + 8'h08, 34'h2, "length count");
    rd_chk(OFS_RETRY, 34'h1, "retry count");
    $display("receive filter done");
    @(posedge CLK);
    CONFIG_ERROR <= '1;
    @(posedge CLK);
    CONFIG_ERROR <= '0;
    rx(mk(11'h040, 4'h9, 8'h05, 8'h01, 8'h03, '1, 7'h01, '0));
    repeat (60) @(posedge CLK);
    chk(CHAN_INITIAL, 40'h1, "initial");
    // only the driver kind is enabled now; link and reset must stay silent
    pulse(3'h0, 3'h2, 8'h3c);
    TX_ALLOW <= '0;
    slow <= '1;
    pulse(3'h7, 3'h0, 8'h00);
    repeat (10) @(posedge CLK);
    chk(NOTICE_VALID, 40'h0, "held while barred");
    TX_ALLOW <= '1;
    wait_got(4);
    repeat (30) @(posedge CLK);
    chk(host.got.size(), 40'h4, "enabled kinds only");
    chk(host.got[3], {8'h05, NOTICE_IID, 8'h3c, NOTICE_TYPE, 8'h01}, "new tag");
    $display("notice gating done");
    // nonzero response code sets the sticky flag; a late failure leaves active
    RESP_VALID <= '1;
    RESP_CODE <= 16'h0003;
    CMD_LATE_FAIL <= '1;
    @(posedge CLK);
    RESP_VALID <= '0;
    CMD_LATE_FAIL <= '0;
    rd_chk(OFS_STATUS, 34'h10102, "sync error set, entry");
    axw(OFS_STATUS, 32'h100);
    chk(r, 40'h0, "status clear write");
    rd_chk(OFS_STATUS, 34'h10002, "sync error cleared");
    $display("error handling done");
    tally_and_finish();
  end
endmodule
